/* File: cef_top.sv */
// two-channel comparator control with apb registers
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_top
   import cef_pkg::*;
#(
   parameter int NUM_CH = 2
)
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`CEF_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [NUM_CH-1:0]      cmp_raw,
   output logic      [NUM_CH-1:0]      compare_enable,
   output logic                        speed_select_bit,
   output logic      [NUM_CH-1:0]      compare_irq,
   output logic      [NUM_CH-1:0]      result_out_pin,
   output logic      [NUM_CH-1:0]      result_out_pin_oe
);
   typedef struct packed {
      logic                     ack;
      logic                     clk_en;
      logic [NUM_CH-1:0]        enb;
      logic                     speed;
      logic [7:0]               fir;
      logic [7:0]               ocr;
      logic [`CEF_DIV_BITS-1:0] div;
      logic [31:0]              rdata;
      logic                     slverr;
   } cef_top_s;
   cef_top_s st_reg;
   cef_top_s st_next;

   logic                 rst_sync_b;
   logic [NUM_CH-1:0]    cmp_sync;
   logic [NUM_CH-1:0]    mon;
   logic [NUM_CH-1:0]    pend;
   logic [NUM_CH-1:0]    clr;
   logic                 acc;
   logic                 wr;
   logic                 rd;
   logic                 tick8;
   logic                 tick32;

   // reset release through two flops; async assert takes constants only
   logic [1:0] rs_reg;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rs_reg <= 2'b00;
      end else begin
         rs_reg <= {rs_reg[0], 1'b1};
      end
   end
   assign rst_sync_b = rs_reg[1];

   // first access cycle loads read data and the error flag; the second one answers
   assign acc    = psel & penable & ~st_reg.ack;
   assign wr     = psel & penable & pwrite & st_reg.ack;
   assign rd     = acc & ~pwrite;
   assign tick8  = (st_reg.div[2:0] == `CEF_DIV8_LAST);
   assign tick32 = (st_reg.div[4:0] == `CEF_DIV32_LAST);

   function automatic logic hit_ofs(input logic [`CEF_ADDR_W-1:0] a,
                                    input logic [`CEF_ADDR_W-1:0] o);
      hit_ofs = (a == o);
   endfunction

   function automatic logic is_mapped(input logic [`CEF_ADDR_W-1:0] a);
      is_mapped = hit_ofs(a, `CEF_OFS_MODE) | hit_ofs(a, `CEF_OFS_FILTER) |
                  hit_ofs(a, `CEF_OFS_OUTCTL) | hit_ofs(a, `CEF_OFS_PERIPH) |
                  hit_ofs(a, `CEF_OFS_IRQ);
   endfunction

   always_comb begin
      clr = '0;
      if (wr && hit_ofs(paddr, `CEF_OFS_IRQ)) begin
         clr = pwdata[NUM_CH-1:0];
      end
   end

   always_comb begin
      st_next          = st_reg;
      st_next.ack      = acc;
      st_next.div      = st_reg.div + `CEF_DIV_BITS'(1);
      st_next.slverr   = 1'b0;
      if (wr) begin
         if (hit_ofs(paddr, `CEF_OFS_MODE)) begin
            st_next.enb[0] = pwdata[`CEF_MODE_ENB0];
            st_next.enb[1] = pwdata[`CEF_MODE_ENB1];
            st_next.speed  = pwdata[`CEF_MODE_SPEED];
         end else if (hit_ofs(paddr, `CEF_OFS_FILTER)) begin
            st_next.fir = pwdata[7:0];
         end else if (hit_ofs(paddr, `CEF_OFS_OUTCTL)) begin
            st_next.ocr = pwdata[7:0];
         end else if (hit_ofs(paddr, `CEF_OFS_PERIPH)) begin
            st_next.clk_en = pwdata[0];
         end
      end
      if (acc && pwrite && !is_mapped(paddr)) begin
         st_next.slverr = 1'b1;
      end
      if (rd) begin
         st_next.rdata = 32'h0;
         if (hit_ofs(paddr, `CEF_OFS_MODE)) begin
            st_next.rdata[`CEF_MODE_ENB0]  = st_reg.enb[0];
            st_next.rdata[`CEF_MODE_MON0]  = mon[0];
            st_next.rdata[`CEF_MODE_ENB1]  = st_reg.enb[1];
            st_next.rdata[`CEF_MODE_MON1]  = mon[1];
            st_next.rdata[`CEF_MODE_SPEED] = st_reg.speed;
         end else if (hit_ofs(paddr, `CEF_OFS_FILTER)) begin
            st_next.rdata[7:0] = st_reg.fir;
         end else if (hit_ofs(paddr, `CEF_OFS_OUTCTL)) begin
            st_next.rdata[7:0] = st_reg.ocr;
         end else if (hit_ofs(paddr, `CEF_OFS_PERIPH)) begin
            st_next.rdata[0] = st_reg.clk_en;
         end else if (hit_ofs(paddr, `CEF_OFS_IRQ)) begin
            st_next.rdata[NUM_CH-1:0] = pend;
         end else begin
            st_next.slverr = 1'b1;
         end
      end
      // stopping the clock supply returns all control registers to reset values
      if (!st_reg.clk_en && !(wr && hit_ofs(paddr, `CEF_OFS_PERIPH) && pwdata[0])) begin
         st_next.enb   = '0;
         st_next.speed = 1'b0;
         st_next.fir   = `CEF_FIR_RESET;
         st_next.ocr   = `CEF_OCR_RESET;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // read data comes from a flop, so every access phase holds one wait state
   assign pready  = psel & penable & st_reg.ack;
   assign prdata  = st_reg.rdata;
   assign pslverr = pready & st_reg.slverr;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         cef_sync u_sync (
            .core_clk   (core_clk),
            .rst_sync_b (rst_sync_b),
            .async_in   (cmp_raw[g]),
            .sync_out   (cmp_sync[g])
         );
         cef_chan u_chan (
            .core_clk             (core_clk),
            .rst_sync_b           (rst_sync_b),
            .cmp_sync             (cmp_sync[g] & st_reg.enb[g]),
            .compare_enable_bit   (st_reg.enb[g]),
            .filter_clock_select  (st_reg.fir[g*`CEF_FIR_STRIDE +: 2]),
            .edge_polarity_select (st_reg.fir[g*`CEF_FIR_STRIDE + `CEF_FIR_POL]),
            .both_edge_select     (st_reg.fir[g*`CEF_FIR_STRIDE + `CEF_FIR_BOTH]),
            .irq_enable_bit       (st_reg.ocr[g*`CEF_OCR_STRIDE + `CEF_OCR_IE]),
            .pin_output_enable    (st_reg.ocr[g*`CEF_OCR_STRIDE + `CEF_OCR_PE]),
            .output_polarity_bit  (st_reg.ocr[g*`CEF_OCR_STRIDE + `CEF_OCR_POL]),
            .sample_tick_div8     (tick8),
            .sample_tick_div32    (tick32),
            .flag_clear           (clr[g] | ~st_reg.clk_en),
            .result_monitor_bit   (mon[g]),
            .irq_pending_flag     (pend[g]),
            .compare_irq          (compare_irq[g]),
            .result_out_pin       (result_out_pin[g]),
            .result_out_pin_oe    (result_out_pin_oe[g])
         );
      end
   endgenerate

   assign compare_enable   = st_reg.enb;
   assign speed_select_bit = st_reg.speed;

   property p_clk_off_clears;
      @(posedge core_clk) disable iff (!rst_sync_b)
         (!st_reg.clk_en && !wr) |=> (st_reg.fir == `CEF_FIR_RESET && st_reg.ocr == `CEF_OCR_RESET);
   endproperty
   a_clk_off_clears: assert property (p_clk_off_clears) else $error("regs not cleared");
endmodule

/* File: cef_consts.svh */
// constants and register map for the comparator edge/filter/output block
`ifndef CEF_CONSTS_SVH
`define CEF_CONSTS_SVH
`define CEF_ADDR_W          8
`define CEF_OFS_MODE        8'h00
`define CEF_OFS_FILTER      8'h04
`define CEF_OFS_OUTCTL      8'h08
`define CEF_OFS_PERIPH      8'h0c
`define CEF_OFS_IRQ         8'h10
// mode register: per channel n, enable at bit 4n, monitor at bit 4n+3, speed at bit 8
`define CEF_MODE_ENB0       0
`define CEF_MODE_MON0       3
`define CEF_MODE_ENB1       4
`define CEF_MODE_MON1       7
`define CEF_MODE_SPEED      8
// filter register: per channel n at 4n: clock select [1:0], polarity [2], both-edge [3]
`define CEF_FIR_STRIDE      4
// output control register: per channel n at 4n: irq enable [0], pin enable [1], pol [2]
`define CEF_OCR_STRIDE      4
`define CEF_FIR_POL         2
`define CEF_FIR_BOTH        3
`define CEF_OCR_IE          0
`define CEF_OCR_PE          1
`define CEF_OCR_POL         2
`define CEF_DIV8_LAST       3'h7
`define CEF_DIV32_LAST      5'h1f
`define CEF_FCK_OFF         2'b00
`define CEF_FIR_RESET       8'h00
`define CEF_OCR_RESET       8'h00
`define CEF_MATCH_COUNT     2'd3
`define CEF_DIV_BITS        6
`endif

/* File: cef_pkg.sv */
// types for the comparator edge/filter/output block
package cef_pkg;
   typedef enum logic [1:0] {CEF_FCK_NONE, CEF_FCK_DIV1, CEF_FCK_DIV8, CEF_FCK_DIV32} cef_fck_e;
endpackage

/* File: cef_sync.sv */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_sync
   import cef_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_sync_b,
   input  wire logic async_in,
   output logic      sync_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } cef_sync_s;
   cef_sync_s st_reg;
   cef_sync_s st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // first stage read only by the second
      if (st_reg.s2 == st_reg.s3) begin
         st_next.q = st_reg.s3;
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.q;
endmodule

/* File: cef_chan.sv */
// one comparator channel: filter, edge detect, pending flag and pin output
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_chan
   import cef_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_sync_b,
   input  wire logic       cmp_sync,
   input  wire logic       compare_enable_bit,
   input  wire logic [1:0] filter_clock_select,
   input  wire logic       edge_polarity_select,
   input  wire logic       both_edge_select,
   input  wire logic       irq_enable_bit,
   input  wire logic       output_polarity_bit,
   input  wire logic       pin_output_enable,
   input  wire logic       sample_tick_div8,
   input  wire logic       sample_tick_div32,
   input  wire logic       flag_clear,
   output logic            result_monitor_bit,
   output logic            irq_pending_flag,
   output logic            compare_irq,
   output logic            result_out_pin,
   output logic            result_out_pin_oe
);
   typedef struct packed {
      logic       filt;
      logic       last;
      logic [1:0] cnt;
      logic       qual_d;
      logic       pend;
      logic       irq;
      logic       pin;
      logic       oe;
   } cef_chan_s;
   cef_chan_s st_reg;
   cef_chan_s st_next;

   logic tick;
   logic qual;
   logic rise;
   logic fall;
   logic hit;

   always_comb begin
      case (cef_fck_e'(filter_clock_select))
         CEF_FCK_DIV1:  tick = 1'b1;
         CEF_FCK_DIV8:  tick = sample_tick_div8;
         CEF_FCK_DIV32: tick = sample_tick_div32;
         default:       tick = 1'b0;
      endcase
   end

   assign qual = (filter_clock_select == `CEF_FCK_OFF) ? cmp_sync : st_reg.filt;
   assign rise = qual & ~st_reg.qual_d;
   assign fall = ~qual & st_reg.qual_d;
   assign hit = compare_enable_bit & irq_enable_bit &
                (both_edge_select ? (rise | fall)
                 : (edge_polarity_select ? fall : rise));

   always_comb begin
      st_next        = st_reg;
      st_next.qual_d = compare_enable_bit ? qual : st_reg.qual_d;
      if (!compare_enable_bit) begin
         st_next.qual_d = qual;
      end
      if (tick) begin
         st_next.last = cmp_sync;
         if (cmp_sync != st_reg.last) begin
            st_next.cnt = 2'd1;
         end else if (st_reg.cnt == `CEF_MATCH_COUNT) begin
            st_next.filt = st_reg.last;
         end else begin
            st_next.cnt = st_reg.cnt + 2'd1;
         end
      end
      if (filter_clock_select == `CEF_FCK_OFF) begin
         st_next.filt = cmp_sync;
         st_next.cnt  = 2'd0;
      end
      // set wins over clear
      if (hit) begin
         st_next.pend = 1'b1;
      end else if (flag_clear) begin
         st_next.pend = 1'b0;
      end
      st_next.irq = hit;
      st_next.pin = pin_output_enable & (qual ^ output_polarity_bit);
      st_next.oe  = pin_output_enable;
   end

   always_ff @(posedge core_clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign result_monitor_bit = cmp_sync;
   assign irq_pending_flag   = st_reg.pend;
   assign compare_irq        = st_reg.irq;
   assign result_out_pin     = st_reg.pin;
   assign result_out_pin_oe  = st_reg.oe;

   property p_pend_set;
      @(posedge core_clk) disable iff (!rst_sync_b) hit |=> st_reg.pend;
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending flag not set");
   property p_irq_pulse;
      @(posedge core_clk) disable iff (!rst_sync_b) hit |=> compare_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq not raised");
   property p_no_rise_only_fall;
      @(posedge core_clk) disable iff (!rst_sync_b)
         (!both_edge_select && edge_polarity_select && rise) |-> !hit;
   endproperty
   a_no_rise_only_fall: assert property (p_no_rise_only_fall) else $error("rise hit");
   property p_no_fall_only_rise;
      @(posedge core_clk) disable iff (!rst_sync_b)
         (!both_edge_select && !edge_polarity_select && fall) |-> !hit;
   endproperty
   a_no_fall_only_rise: assert property (p_no_fall_only_rise) else $error("fall hit");
   property p_both;
      @(posedge core_clk) disable iff (!rst_sync_b)
         (both_edge_select && compare_enable_bit && irq_enable_bit && (rise || fall)) |=> compare_irq;
   endproperty
   a_both: assert property (p_both) else $error("both-edge miss");
   property p_disabled;
      @(posedge core_clk) disable iff (!rst_sync_b) !compare_enable_bit |=> !compare_irq;
   endproperty
   a_disabled: assert property (p_disabled) else $error("irq while disabled");
   property p_pin_off;
      @(posedge core_clk) disable iff (!rst_sync_b)
         !pin_output_enable |=> (!result_out_pin_oe && !result_out_pin);
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
   property p_pin_pol;
      @(posedge core_clk) disable iff (!rst_sync_b)
         pin_output_enable |=> result_out_pin == ($past(qual) ^ $past(output_polarity_bit));
   endproperty
   a_pin_pol: assert property (p_pin_pol) else $error("pin polarity wrong");
   property p_bypass;
      @(posedge core_clk) disable iff (!rst_sync_b)
         (filter_clock_select == `CEF_FCK_OFF) |-> qual == cmp_sync;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass not raw");
   property p_filt_hold;
      @(posedge core_clk) disable iff (!rst_sync_b)
         (filter_clock_select != `CEF_FCK_OFF && !tick) |=> st_reg.filt == $past(st_reg.filt);
   endproperty
   a_filt_hold: assert property (p_filt_hold) else $error("filter moved off tick");
endmodule

/* File: comparator_edge_filter_output_tb.sv */
// self-checking bench for the comparator edge/filter/output block
`timescale 1ns/1ps
`include "cef_consts.svh"
module comparator_edge_filter_output_tb import cef_pkg::*;;
   logic                   core_clk;
   logic                   rst_b;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [`CEF_ADDR_W-1:0] paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [1:0]             cmp_raw;
   logic [1:0]             compare_enable;
   logic                   speed_select_bit;
   logic [1:0]             compare_irq;
   logic [1:0]             result_out_pin;
   logic [1:0]             result_out_pin_oe;
   int                     n_mismatch;
   int                     n_tests;
   int                     irq_cnt [2];
   logic [31:0]            rd;
   logic                   err;

   cef_top #(.NUM_CH(2)) u_cef_top (
      .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
      .compare_enable(compare_enable), .speed_select_bit(speed_select_bit),
      .compare_irq(compare_irq), .result_out_pin(result_out_pin),
      .result_out_pin_oe(result_out_pin_oe));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // counted on the falling edge so tasks never race the pulse itself
   always @(negedge core_clk) begin
      for (int i = 0; i < 2; i++) begin
         if (compare_irq[i] === 1'b1) irq_cnt[i]++;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic setup();
      wr(`CEF_OFS_PERIPH, 32'h1);
      wr(`CEF_OFS_MODE, 32'h11);
      wr(`CEF_OFS_IRQ, 32'h3);
   endtask

   task automatic t_reset();
      for (int a = 0; a < 5; a++) rdchk(8'(4 * a), 32'h0);
      wr(`CEF_OFS_FILTER, 32'hff);
      rdchk(`CEF_OFS_FILTER, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
   endtask

   task automatic t_monitor();
      wr(`CEF_OFS_PERIPH, 32'h1);
      wr(`CEF_OFS_MODE, 32'h100);
      cyc(1);
      chk({31'h0, speed_select_bit}, 32'h1);
      wr(`CEF_OFS_MODE, 32'h0);
      wr(`CEF_OFS_MODE, 32'h11);
      cyc(1);
      chk({30'h0, compare_enable}, 32'h3);
      @(posedge core_clk) cmp_raw <= 2'b11;
      cyc(10);
      rdchk(`CEF_OFS_MODE, 32'h99);
      @(posedge core_clk) cmp_raw <= 2'b01;
      cyc(10);
      rdchk(`CEF_OFS_MODE, 32'h19);
      @(posedge core_clk) cmp_raw <= 2'b00;
      cyc(10);
      rdchk(`CEF_OFS_MODE, 32'h11);
      $display("test monitor done");
   endtask

   // one edge on a channel, then the pulse count and the pending flag
   task automatic edge_chk(input int ch, input logic v, input int exp);
      int c0;
      c0 = irq_cnt[ch];
      @(posedge core_clk) cmp_raw[ch] <= v;
      cyc(12);
      chk(32'(irq_cnt[ch] - c0), 32'(exp));
      rdchk(`CEF_OFS_IRQ, 32'(exp) << ch);
      wr(`CEF_OFS_IRQ, 32'h1 << ch);
      rdchk(`CEF_OFS_IRQ, 32'h0);
   endtask

   task automatic t_edges(input int ch);
      logic [3:0] cfg [3];
      cfg = '{4'h0, 4'h4, 4'h8};
      setup();
      wr(`CEF_OFS_OUTCTL, 32'h1 << (4 * ch));
      for (int m = 0; m < 3; m++) begin
         wr(`CEF_OFS_FILTER, 32'(cfg[m]) << (4 * ch));
         edge_chk(ch, 1'b1, (m != 1) ? 1 : 0);
         edge_chk(ch, 1'b0, (m != 0) ? 1 : 0);
      end
      $display("test edges done");
   endtask

   task automatic t_gate();
      setup();
      wr(`CEF_OFS_FILTER, 32'h8);
      edge_chk(0, 1'b1, 0);
      edge_chk(0, 1'b0, 0);
      wr(`CEF_OFS_OUTCTL, 32'h1);
      wr(`CEF_OFS_MODE, 32'h10);
      edge_chk(0, 1'b1, 0);
      edge_chk(0, 1'b0, 0);
      $display("test gate done");
   endtask

   task automatic t_filter(input int ch);
      cef_fck_e f;
      int c0;
      setup();
      wr(`CEF_OFS_OUTCTL, 32'h1 << (4 * ch));
      for (int i = 0; i < 4; i++) begin
         f = cef_fck_e'(i);
         wr(`CEF_OFS_FILTER, 32'({2'b10, f}) << (4 * ch));
         wr(`CEF_OFS_IRQ, 32'h3);
         c0 = irq_cnt[ch];
         // a short glitch survives only the bypass path
         @(posedge core_clk) cmp_raw[ch] <= 1'b1;
         cyc((f == CEF_FCK_NONE) ? 3 : 2);
         cmp_raw[ch] <= 1'b0;
         cyc(200);
         chk(32'(irq_cnt[ch] - c0), (f == CEF_FCK_NONE) ? 32'h2 : 32'h0);
         @(posedge core_clk) cmp_raw[ch] <= 1'b1;
         cyc(200);
         chk(32'(irq_cnt[ch] - c0), (f == CEF_FCK_NONE) ? 32'h3 : 32'h1);
         @(posedge core_clk) cmp_raw[ch] <= 1'b0;
         cyc(200);
         chk(32'(irq_cnt[ch] - c0), (f == CEF_FCK_NONE) ? 32'h4 : 32'h2);
      end
      $display("test filter done");
   endtask

   task automatic t_pin(input int ch);
      setup();
      wr(`CEF_OFS_FILTER, 32'h0);
      wr(`CEF_OFS_OUTCTL, 32'h0);
      @(posedge core_clk) cmp_raw[ch] <= 1'b1;
      cyc(12);
      chk({31'h0, result_out_pin_oe[ch]}, 32'h0);
      chk({31'h0, result_out_pin[ch]}, 32'h0);
      for (int p = 0; p < 2; p++) begin
         wr(`CEF_OFS_OUTCTL, 32'(2 + 4 * p) << (4 * ch));
         for (int v = 0; v < 2; v++) begin
            @(posedge core_clk) cmp_raw[ch] <= v[0];
            cyc(12);
            chk({31'h0, result_out_pin_oe[ch]}, 32'h1);
            chk({31'h0, result_out_pin[ch]}, 32'(v ^ p));
         end
      end
      $display("test pin done");
   endtask

   task automatic t_clkoff();
      setup();
      wr(`CEF_OFS_FILTER, 32'h88);
      wr(`CEF_OFS_OUTCTL, 32'h22);
      wr(`CEF_OFS_OUTCTL, 32'h0);
      wr(`CEF_OFS_IRQ, 32'h3);
      wr(`CEF_OFS_MODE, 32'h0);
      wr(`CEF_OFS_OUTCTL, 32'h22);
      wr(`CEF_OFS_PERIPH, 32'h0);
      cyc(3);
      chk({30'h0, result_out_pin_oe}, 32'h0);
      wr(`CEF_OFS_PERIPH, 32'h1);
      for (int a = 0; a < 3; a++) rdchk(8'(4 * a), 32'h0);
      $display("test clock-off done");
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      cmp_raw = 2'b00;
      n_mismatch = 0;
      n_tests = 0;
      cyc(4);
      rst_b <= 1'b1;
      cyc(3);
      t_reset();
      t_monitor();
      t_edges(0);
      t_edges(1);
      t_gate();
      t_filter(0);
      t_filter(1);
      t_pin(0);
      t_pin(1);
      t_clkoff();
      finish_test();
   end

   // the tests need under 10000 cycles; this margin only cuts a hang
   initial begin
      #(8 * 60000);
      n_mismatch++;
      finish_test();
   end
endmodule
